// ===== common/bsmc_params.svh
// constants for the byte string move / compare datapath
// assumes 16-bit words, byte addresses with bit 0 selecting the byte
`ifndef BSMC_PARAMS_SVH
`define BSMC_PARAMS_SVH
`define BSMC_WORD_W     16
`define BSMC_WADDR_W    15
`define BSMC_LEN_W      8
`define BSMC_FIFO_DEPTH 8
`define BSMC_ZERO16     16'h0000
`define BSMC_ZERO8      8'h00
`define BSMC_ONE8       8'h01
`define BSMC_ONE16      16'h0001
`define BSMC_PARAM1_OFS 15'h0001
`define BSMC_PARAM2_OFS 15'h0002
`define BSMC_SKIP_NONE  2'h0
`define BSMC_SKIP_ONE   2'h1
`define BSMC_SKIP_TWO   2'h2
`endif

// ===== common/bsmc_pkg.sv
// types shared by the string datapath, its memory model and the bench
// assumes bsmc_params.svh is on the include path
package bsmc_pkg;
`include "bsmc_params.svh"
	typedef enum logic {OP_MOVE, OP_COMPARE} string_op_t;
	typedef enum logic [2:0] {S_IDLE, S_REQ, S_WAIT, S_STEP, S_DONE} state_t;
	typedef enum logic [2:0] {PH_P1, PH_I1, PH_P2, PH_I2, PH_SRC, PH_DST, PH_WR} phase_t;
	// instruction handed over by the sequencer
	typedef struct packed {
		string_op_t               op;
		logic                     src_ind;
		logic                     dst_ind;
		logic [`BSMC_WADDR_W-1:0] pc;
		logic [`BSMC_WORD_W-1:0]  a;
		logic [`BSMC_WORD_W-1:0]  x;
		logic                     overflow_flag;
	} start_t;
	// one memory cycle request
	typedef struct packed {
		logic                     we;
		logic [`BSMC_WADDR_W-1:0] addr;
		logic [`BSMC_WORD_W-1:0]  wdata;
	} mem_cmd_t;
	// register image returned at the end
	typedef struct packed {
		logic [`BSMC_WORD_W-1:0] a;
		logic [`BSMC_WORD_W-1:0] x;
		logic [1:0]              skip;
		logic                    interrupted;
		logic                    overflow_flag;
	} result_t;
endpackage

// ===== design/byte_string_move_compare.sv
// byte string move and compare-and-skip execution datapath, with read data fifo
// assumes a word memory with one outstanding cycle and a sequencer that re-executes on interrupt
`timescale 1ns/10ps
`include "bsmc_params.svh"

module bsmc_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 8
) (
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0]  mem_q [DEPTH];  // storage words
	logic [AW-1:0] wr_q;           // write pointer
	logic [AW-1:0] rd_q;           // read pointer
	logic [AW:0]   cnt_q;          // words held
	logic          push;
	logic          pop;

	// compare at the counter's own width; a pointer-wide cast of the depth would wrap to zero
	assign in_ready  = (cnt_q != (AW+1)'(DEPTH)); // full stalls the memory return
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// storage write, no reset needed on data
	always_ff @(posedge clock) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// pointers and occupancy
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

module byte_string_move_compare import bsmc_pkg::*; (
	input  wire logic                     clock,
	input  wire logic                     rst,
	input  wire logic                     start,      // one-cycle instruction issue
	input  wire start_t                   start_info,
	input  wire logic                     irq_pend,   // interrupt waiting to be taken
	output logic                          busy,
	output logic                          done,       // one-cycle completion
	output result_t                       result,
	output logic                          mem_req,
	output mem_cmd_t                      mem_cmd,
	input  wire logic                     mem_gnt,
	input  wire logic                     rd_valid,
	output logic                          rd_ready,
	input  wire logic [`BSMC_WORD_W-1:0]  rd_data
);
	state_t                   state_q;   // sequencer state
	phase_t                   phase_q;   // what the pending cycle is for
	string_op_t               op_q;
	logic                     sind_q;    // source parameter is a pointer
	logic                     dind_q;    // destination parameter is a pointer
	logic [`BSMC_WADDR_W-1:0] pc_q;
	logic [`BSMC_WORD_W-1:0]  src_q;     // resolved source byte address
	logic [`BSMC_WORD_W-1:0]  dst_q;     // resolved destination byte address
	logic [`BSMC_WORD_W-1:0]  a_q;       // live progress: position
	logic [`BSMC_WORD_W-1:0]  x_q;       // live progress: remaining in low byte
	logic [`BSMC_WORD_W-1:0]  a_ent_q;   // values at entry for restoring
	logic [`BSMC_WORD_W-1:0]  x_ent_q;
	logic                     ov_q;      // overflow flag, carried only
	logic [7:0]               sbyte_q;   // source byte in hand
	mem_cmd_t                 cmd_q;
	result_t                  res_q;
	logic                     f_valid;
	logic [`BSMC_WORD_W-1:0]  f_data;
	logic                     f_pop;
	logic [7:0]               dbyte;     // destination byte of the returned word

	// byte address to word address
	function automatic logic [`BSMC_WADDR_W-1:0] word_of(input logic [`BSMC_WORD_W-1:0] b);
		return b[`BSMC_WORD_W-1:1];
	endfunction

	// even byte is the left (high) half of the word
	function automatic logic [7:0] pick(input logic [`BSMC_WORD_W-1:0] w, input logic odd);
		return odd ? w[7:0] : w[15:8];
	endfunction

	assign busy     = (state_q != S_IDLE);
	assign done     = (state_q == S_DONE);
	assign result   = res_q;
	assign mem_req  = (state_q == S_REQ);
	assign mem_cmd  = cmd_q;
	assign f_pop    = (state_q == S_WAIT);
	assign dbyte    = pick(f_data, dst_q[0] ^ a_q[0]);

	// read returns queue here; a full queue back-pressures the memory
	bsmc_fifo #(.W(`BSMC_WORD_W), .DEPTH(`BSMC_FIFO_DEPTH)) u_rd_fifo (
		.clock     (clock),
		.rst       (rst),
		.in_valid  (rd_valid),
		.in_ready  (rd_ready),
		.in_data   (rd_data),
		.out_valid (f_valid),
		.out_ready (f_pop),
		.out_data  (f_data)
	);

	// sequencer: parameter fetch, indirection, then one byte per pass
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= S_IDLE;
			phase_q <= PH_P1;
			op_q    <= OP_MOVE;
			sind_q  <= 1'b0;
			dind_q  <= 1'b0;
			pc_q    <= '0;
			src_q   <= `BSMC_ZERO16;
			dst_q   <= `BSMC_ZERO16;
			a_q     <= `BSMC_ZERO16;
			x_q     <= `BSMC_ZERO16;
			a_ent_q <= `BSMC_ZERO16;
			x_ent_q <= `BSMC_ZERO16;
			ov_q    <= 1'b0;
			sbyte_q <= `BSMC_ZERO8;
			cmd_q   <= '0;
			res_q   <= '0;
		end else begin
			unique case (state_q)
				S_IDLE: begin
					if (start) begin
						op_q    <= start_info.op;
						sind_q  <= start_info.src_ind;
						dind_q  <= start_info.dst_ind;
						pc_q    <= start_info.pc;
						a_q     <= start_info.a;
						x_q     <= start_info.x;
						a_ent_q <= start_info.a;
						x_ent_q <= start_info.x;
						ov_q    <= start_info.overflow_flag;
						if (start_info.x[`BSMC_LEN_W-1:0] == `BSMC_ZERO8) begin
							res_q   <= '{start_info.a, start_info.x, `BSMC_SKIP_NONE, 1'b0,
								start_info.overflow_flag};
							state_q <= S_DONE;
						end else begin
							cmd_q   <= '{1'b0, start_info.pc + `BSMC_PARAM1_OFS, `BSMC_ZERO16};
							phase_q <= PH_P1;
							state_q <= S_REQ;
						end
					end
				end
				S_REQ: begin
					// writes end on grant, reads wait for their data
					if (mem_gnt) begin
						state_q <= cmd_q.we ? S_STEP : S_WAIT;
					end
				end
				S_WAIT: begin
					if (f_valid) begin
						state_q <= S_REQ;
						unique case (phase_q)
							PH_P1: begin
								src_q <= f_data;
								if (sind_q) begin
									cmd_q   <= '{1'b0, f_data[`BSMC_WADDR_W-1:0], `BSMC_ZERO16};
									phase_q <= PH_I1;
								end else begin
									cmd_q   <= '{1'b0, pc_q + `BSMC_PARAM2_OFS, `BSMC_ZERO16};
									phase_q <= PH_P2;
								end
							end
							PH_I1: begin
								// pointer content is taken as the byte address, no further level
								src_q   <= f_data;
								cmd_q   <= '{1'b0, pc_q + `BSMC_PARAM2_OFS, `BSMC_ZERO16};
								phase_q <= PH_P2;
							end
							PH_P2: begin
								dst_q <= f_data;
								if (dind_q) begin
									cmd_q   <= '{1'b0, f_data[`BSMC_WADDR_W-1:0], `BSMC_ZERO16};
									phase_q <= PH_I2;
								end else begin
									cmd_q   <= '{1'b0, word_of(src_q + a_q), `BSMC_ZERO16};
									phase_q <= PH_SRC;
								end
							end
							PH_I2: begin
								dst_q   <= f_data;
								cmd_q   <= '{1'b0, word_of(src_q + a_q), `BSMC_ZERO16};
								phase_q <= PH_SRC;
							end
							PH_SRC: begin
								sbyte_q <= pick(f_data, src_q[0] ^ a_q[0]);
								cmd_q   <= '{1'b0, word_of(dst_q + a_q), `BSMC_ZERO16};
								phase_q <= PH_DST;
							end
							PH_DST: begin
								if (op_q == OP_MOVE) begin
									// read-modify-write keeps the partner byte of the word
									cmd_q.we    <= 1'b1;
									cmd_q.wdata <= (dst_q[0] ^ a_q[0]) ? {f_data[15:8], sbyte_q}
										: {sbyte_q, f_data[7:0]};
									phase_q     <= PH_WR;
								end else begin
									a_q[`BSMC_WORD_W-1:0] <= a_q;
									x_q[7:0] <= x_q[7:0] - `BSMC_ONE8;
									if (sbyte_q == dbyte) begin
										a_q     <= a_q + `BSMC_ONE16;
										state_q <= S_STEP;
									end else begin
										// unsigned magnitude decides the skip distance
										res_q   <= '{a_q, {x_q[15:8], x_q[7:0] - `BSMC_ONE8},
											(sbyte_q < dbyte) ? `BSMC_SKIP_ONE : `BSMC_SKIP_NONE,
											1'b0, ov_q};
										state_q <= S_DONE;
									end
								end
							end
							default: begin
								state_q <= S_IDLE;
							end
						endcase
					end
				end
				S_STEP: begin
					// after a move write the byte counts as done; one byte per pass keeps
					// the strict forward order that overlapping regions rely on
					if (phase_q == PH_WR) begin
						a_q      <= a_q + `BSMC_ONE16;
						x_q[7:0] <= x_q[7:0] - `BSMC_ONE8;
						phase_q  <= PH_SRC;
					end else if (x_q[7:0] == `BSMC_ZERO8) begin
						res_q   <= '{a_ent_q, x_ent_q, (op_q == OP_COMPARE) ? `BSMC_SKIP_TWO : `BSMC_SKIP_NONE,
							1'b0, ov_q};
						state_q <= S_DONE;
					end else if (irq_pend) begin
						res_q   <= '{a_q, x_q, `BSMC_SKIP_NONE, 1'b1, ov_q};
						state_q <= S_DONE;
					end else begin
						cmd_q   <= '{1'b0, word_of(src_q + a_q), `BSMC_ZERO16};
						phase_q <= PH_SRC;
						state_q <= S_REQ;
					end
				end
				S_DONE: begin
					state_q <= S_IDLE;
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	zero_len_nop_a: assert property (@(posedge clock) disable iff (rst)
		(state_q == S_IDLE && start && start_info.x[7:0] == `BSMC_ZERO8) |=> done && !mem_req ##1 !mem_req)
		else $error("zero length touched memory");
	// long strings run for thousands of cycles, so the flag is checked at latch and at done
	ov_carried_a: assert property (@(posedge clock) disable iff (rst)
		done |-> (result.overflow_flag == ov_q))
		else $error("overflow flag altered");
	ov_latch_a: assert property (@(posedge clock) disable iff (rst)
		(state_q == S_IDLE && start) |=> (ov_q == $past(start_info.overflow_flag)))
		else $error("overflow flag not latched");
	move_restore_a: assert property (@(posedge clock) disable iff (rst)
		(done && op_q == OP_MOVE && !result.interrupted) |-> (result.a == a_ent_q && result.x == x_ent_q))
		else $error("move changed A or X");
	match_skip_a: assert property (@(posedge clock) disable iff (rst)
		(done && result.skip == `BSMC_SKIP_TWO) |-> (result.a == a_ent_q && result.x == x_ent_q))
		else $error("full match altered A or X");
	skip_sense_a: assert property (@(posedge clock) disable iff (rst)
		(f_pop && f_valid && phase_q == PH_DST && op_q == OP_COMPARE && sbyte_q != dbyte)
		|=> done && result.skip == (($past(sbyte_q) < $past(dbyte)) ? `BSMC_SKIP_ONE : `BSMC_SKIP_NONE))
		else $error("wrong skip after mismatch");
	mismatch_pos_a: assert property (@(posedge clock) disable iff (rst)
		(f_pop && f_valid && phase_q == PH_DST && op_q == OP_COMPARE && sbyte_q != dbyte)
		|=> result.a == $past(a_q) && result.x[7:0] == $past(x_q[7:0]) - `BSMC_ONE8)
		else $error("mismatch record wrong");
	irq_stop_a: assert property (@(posedge clock) disable iff (rst)
		(state_q == S_STEP && phase_q != PH_WR && x_q[7:0] != `BSMC_ZERO8 && irq_pend)
		|=> done && result.interrupted && result.x == $past(x_q) && result.a == $past(a_q))
		else $error("interrupt not taken at byte boundary");
	len_high_a: assert property (@(posedge clock) disable iff (rst)
		(state_q == S_STEP) |-> x_q[15:8] == x_ent_q[15:8])
		else $error("upper X bits disturbed");
	param_fetch_a: assert property (@(posedge clock) disable iff (rst)
		(state_q == S_IDLE && start && start_info.x[7:0] != `BSMC_ZERO8)
		|=> mem_req && !mem_cmd.we && mem_cmd.addr == $past(start_info.pc) + `BSMC_PARAM1_OFS)
		else $error("first parameter not fetched");
	write_addr_a: assert property (@(posedge clock) disable iff (rst)
		(mem_req && mem_cmd.we) |-> mem_cmd.addr == word_of(dst_q + a_q))
		else $error("move write to wrong word");
endmodule

// ===== bench/bsmc_mem_model.sv
// word memory behind the string datapath, one read outstanding
// assumes the bench preloads mem by hierarchy and drives slow off the clock edge
`timescale 1ns/10ps
module bsmc_mem_model import bsmc_pkg::*; (
	input  wire logic     clock,
	input  wire logic     rst,
	input  wire logic     slow,     // random stalls on grant and return
	input  wire logic     mem_req,
	input  wire mem_cmd_t mem_cmd,
	output logic          mem_gnt,
	output logic          rd_valid,
	input  wire logic     rd_ready,
	output logic [15:0]   rd_data
);
	logic [15:0] mem [0:32767]; // whole word space
	logic [15:0] held_q;        // word fetched at the grant
	logic        pend_q;        // fetched word not yet offered
	// grant, then return; slow mode holds either back a cycle at a time
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			mem_gnt  <= 1'b0;
			rd_valid <= 1'b0;
			rd_data  <= 16'hA5A5;
			pend_q   <= 1'b0;
		end else begin
			mem_gnt <= mem_req && !mem_gnt && (!slow || $urandom_range(1) == 1);
			if (mem_req && mem_gnt) begin
				if (mem_cmd.we) begin
					mem[mem_cmd.addr] <= mem_cmd.wdata;
				end else begin
					pend_q <= 1'b1;
					held_q <= mem[mem_cmd.addr];
				end
			end
			if (rd_valid && rd_ready) begin
				rd_valid <= 1'b0;
				rd_data  <= ~rd_data; // released lines must not keep the old word
			end else if (pend_q && !rd_valid && (!slow || $urandom_range(1) == 1)) begin
				rd_valid <= 1'b1;
				rd_data  <= held_q;
				pend_q   <= 1'b0;
			end
		end
	end
endmodule

// ===== bench/testbench.sv
// self-checking bench for the string move and compare datapath
// assumes the memory model answers every request; byte model kept in img
`timescale 1ns/10ps
module testbench import bsmc_pkg::*; ;
	localparam int          LIMIT = 95000;   // cycle ceiling for the run
	localparam logic [14:0] PC    = 15'h0040; // word address of the opcode
	logic        clock, rst, start, irq_pend, irq_on, slow;
	logic        busy, done, mem_req, mem_gnt, rd_valid, rd_ready;
	start_t      info;
	result_t     result;
	mem_cmd_t    mem_cmd;
	logic [15:0] rd_data;
	logic [7:0]  img [0:8191]; // byte image of words 0..FFF
	int          miscompares, comparisons, cycles, reqs;

	byte_string_move_compare dut_u (.clock(clock), .rst(rst), .start(start), .start_info(info),
		.irq_pend(irq_pend), .busy(busy), .done(done), .result(result), .mem_req(mem_req),
		.mem_cmd(mem_cmd), .mem_gnt(mem_gnt), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
	bsmc_mem_model mem_u (.clock(clock), .rst(rst), .slow(slow), .mem_req(mem_req), .mem_cmd(mem_cmd),
		.mem_gnt(mem_gnt), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// cycle ceiling and a count of request cycles for the no-memory check
	always @(posedge clock) begin
		cycles++;
		if (mem_req === 1'b1) reqs++;
		if (cycles == LIMIT) begin
			miscompares++;
			test_done();
		end
	end

	task automatic test_done();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic pw(input int w, input logic [15:0] v);
		img[2*w]   = v[15:8];
		img[2*w+1] = v[7:0];
	endtask
	// one issue at a falling edge; n counts cycles until done
	task automatic issue(input start_t si, output int n);
		while (busy !== 1'b0) @(negedge clock);
		info  = si;
		start = 1'b1;
		@(negedge clock);
		start = 1'b0;
		n = 1;
		while (done !== 1'b1 && n < 20000) begin
			irq_pend = irq_on && ($urandom_range(7) == 0);
			@(negedge clock);
			n++;
		end
		irq_pend = 1'b0;
	endtask
	// whole instruction, re-issued after interrupts and mismatches as software would
	task automatic run(input string_op_t op, input int len, input int so, input int dof);
		start_t si;
		int     s, d, i, n, ea, ex, es, r0;
		logic   go;
		s = 32'h1000 + so; // well below the top byte address
		d = (op == OP_MOVE ? 32'h1000 : 32'h1800) + dof;
		si = '0; // A enters as zero
		si.op = op;
		si.src_ind = 1'($urandom);
		si.dst_ind = 1'($urandom);
		si.pc = PC;
		si.overflow_flag = 1'($urandom);
		si.x = {8'($urandom), 8'(len)}; // upper byte is noise
		pw(PC + 1, si.src_ind ? 16'h0060 : 16'(s));
		pw(32'h60, 16'(s));
		pw(PC + 2, si.dst_ind ? 16'h0061 : 16'(d));
		pw(32'h61, 16'(d));
		for (i = 0; i < 4096; i++) mem_u.mem[i] = {img[2*i], img[2*i+1]};
		for (i = 0; i < len && op == OP_MOVE; i++) img[d+i] = img[s+i]; // forward copy
		slow = 1'($urandom);
		do begin
			r0 = reqs;
			issue(si, n);
			ea = si.a;
			ex = si.x;
			es = 0;
			go = 1'b0;
			chk(done, 1);
			chk(result.overflow_flag, si.overflow_flag);
			if (si.x[7:0] == 8'h00) begin
				chk(n, 1);
				chk(reqs - r0, 0);
			end
			if (irq_on && result.interrupted === 1'b1) begin
				chk(result.a - si.a, si.x[7:0] - result.x[7:0]);
				chk(result.x[7:0] != 0 && result.a != si.a && result.x[15:8] == si.x[15:8], 1);
				go = 1'b1;
			end else begin
				chk(result.interrupted, 0);
				if (op == OP_COMPARE && si.x[7:0] != 8'h00) begin
					es = 2;
					for (i = si.a; i < si.a + si.x[7:0] && es == 2; i++) begin
						if (img[s+i] != img[d+i]) begin
							es = img[s+i] < img[d+i] ? 1 : 0;
							ea = i;
							ex = {si.x[15:8], 8'(si.a + si.x[7:0] - i - 1)};
						end
					end
					go = es < 2;
				end
				chk(result.skip, es);
				chk({result.a, result.x}, {16'(ea), 16'(ex)});
			end
			si.a = result.a + ((go && result.interrupted !== 1'b1) ? 16'h0001 : 16'h0000);
			si.x = result.x;
		end while (go);
		for (i = 32'h7F0; i < 32'h8D0; i++) chk(mem_u.mem[i], {img[2*i], img[2*i+1]});
	endtask

	initial begin
		int k, i, so, dof, len;
		void'($urandom(32'h8e3c));
		{rst, start, irq_pend, irq_on, slow} = 5'h10;
		info = '0;
		for (i = 0; i < 8192; i++) img[i] = 8'($urandom);
		repeat (12) @(negedge clock);
		rst = 1'b0;
		@(negedge clock);
		run(OP_MOVE, 0, 3, 9);
		run(OP_COMPARE, 0, 3, 9);
		for (k = 0; k < 24; k++) begin
			so = $urandom_range(63);
			dof = $urandom_range(63);
			len = (k == 5) ? 255 : $urandom_range(32, 1);
			irq_on = k[0];
			for (i = 0; i < 256; i++) img[32'h1800 + dof + i] = img[32'h1000 + so + i];
			repeat ($urandom_range(3)) img[32'h1800 + dof + $urandom_range(len - 1)] = 8'($urandom);
			if (k == 0) begin
				img[32'h1000 + so] = 8'hFF; // high bit set: unsigned greater
				img[32'h1800 + dof] = 8'h01;
			end
			run(OP_COMPARE, len, so, dof);
			run(OP_MOVE, len, so, dof);
		end
		test_done();
	end
endmodule
